// *** hw/pfc_cfg.svh ***
// Offsets, field positions, reset values and counts for the port flow
// control block. Assumes byte addresses on a 32-bit register port.
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
`define PFC_OFF_CTL 8'h00
`define PFC_OFF_THR 8'h04
`define PFC_OFF_MAC_CONFIG_WORD 8'h08
`define PFC_OFF_MTIM 8'h0c
`define PFC_OFF_SAL 8'h10
`define PFC_OFF_SAH 8'h14
`define PFC_CTL_BP_EN 21
`define PFC_CTL_BP_MODE 22
`define PFC_CTL_FC_HI 24
`define PFC_CTL_FC_LO 23
`define PFC_CTL_STAT_HI 10
`define PFC_THR_HW_HI 30
`define PFC_THR_HW_LO 24
`define PFC_THR_LW_HI 22
`define PFC_THR_LW_LO 16
`define PFC_THR_DUR_HI 15
`define PFC_MAC_CONFIG_WORD_RX_PAUSE 16
`define PFC_MAC_CONFIG_WORD_TX_PAUSE 17
`define PFC_MTIM_CW_HI 9
`define PFC_MTIM_CW_LO 4
`define PFC_FC_PORT 2'h1
`define PFC_FC_PKT 2'h2
`define PFC_FC_FULL 2'h3
`define PFC_CTL_RESET 32'h0100_0000
`define PFC_ZERO_RESET 32'h0000_0000
`define PFC_CW_OFFSET 10'h048
`define PFC_ST_CONG 0
`define PFC_ST_BP 1
`define PFC_ST_JAM 2
`define PFC_ST_PAUSE 3
`define PFC_ST_LATE 4
`endif

// *** hw/pfc_pkg.sv ***
// Types for the port flow control block: transmit tracking states and
// the single packed state record. Assumes pfc_cfg.svh is not needed here.
package pfc_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_XMIT, TX_ABORTED} pfc_tx_e;
  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] thr;
    logic [31:0] mac_config_word;
    logic [31:0] mtim;
    logic [31:0] sal;
    logic [31:0] sah;
    logic [31:0] rdata;
    logic congested;
    logic bp;
    logic jam;
    logic [15:0] timer;
    logic pause_req;
    logic [15:0] pause_time;
    logic pause_sticky;
    logic tx_abort;
    logic late_col;
    logic late_sticky;
    logic [9:0] bit_cnt;
    pfc_tx_e tx_st;
    logic [2:0] txc_s;
    logic [1:0] col_s;
  } pfc_state_s;
endpackage

// *** hw/pfc_port.sv ***
// Per-port flow control, backpressure and collision window logic.
// Assumes queue_depth comes from logic on clock; the PHY transmit clock
// and collision pins are asynchronous and are synchronised here.
// How it works
// - Each port instance has its own control and threshold words.
// - Threshold word bits 30:24 hold the congestion high water mark.
// - Threshold word bits 22:16 hold the low water mark for hysteresis.
// - Control bit 21 switches backpressure on; bit 22 is a companion setting.
// - With control bit 21 clear no backpressure is ever generated.
// - A congested port with backpressure enabled drives backpressure.
// - In half duplex control bits 24:23 pick per-port or per-packet.
// - Per-port mode times each jam with threshold bits 15:0.
// - Per-packet mode jams while congested with no timer.
// - Control bits 24:23 both set select full-duplex pause flow control.
// - Full-duplex pause time comes from threshold bits 15:0.
// - Control word bits 10:0 are read only; bits 4:0 read back congestion and activity status.
// - A collision after the window from timing bits 9:4 aborts transmit.
// - Such a collision flags late collision in the transmit status.
// - Window field 0x37 equals 512 bit times; other values fine tune it.
// - MAC config bit 16 lets received pause frames take effect.
// - MAC config bit 17 lets the port transmit pause frames.
// - Pause frames carry the 48-bit station address words.
// - After reset the port runs in half duplex.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module pfc_port (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [6:0] queue_depth,
  input wire logic tx_active,
  input wire logic phy_txc,
  input wire logic phy_col,
  output logic backpressure,
  output logic bp_mode,
  output logic hd_jam,
  output logic pause_req,
  output logic [15:0] pause_time,
  output logic [47:0] pause_src_addr,
  output logic rx_pause_en,
  output logic tx_abort,
  output logic late_col
);
  pfc_pkg::pfc_state_s st_reg;
  pfc_pkg::pfc_state_s st_next;
  logic [1:0] fc_mode;
  logic bp_en;
  logic [6:0] high_mark;
  logic [6:0] low_mark;
  logic txc_edge;
  logic col_now;
  logic [9:0] cw_limit;
  logic cong_next;
  logic late_hit;

  assign fc_mode = st_reg.ctl[`PFC_CTL_FC_HI:`PFC_CTL_FC_LO];
  assign bp_en = st_reg.ctl[`PFC_CTL_BP_EN];
  assign high_mark = st_reg.thr[`PFC_THR_HW_HI:`PFC_THR_HW_LO];
  assign low_mark = st_reg.thr[`PFC_THR_LW_HI:`PFC_THR_LW_LO];
  assign txc_edge = st_reg.txc_s[1] & ~st_reg.txc_s[2];
  assign col_now = st_reg.col_s[1];
  // Field steps are eight bit times so the window can only be trimmed
  assign cw_limit = {st_reg.mtim[`PFC_MTIM_CW_HI:`PFC_MTIM_CW_LO], 3'h0}
    + `PFC_CW_OFFSET;
  assign late_hit = (st_reg.tx_st == pfc_pkg::TX_XMIT) && col_now
    && (st_reg.bit_cnt > cw_limit);

  always_comb
  begin
    st_next = st_reg;
    st_next.txc_s = {st_reg.txc_s[1:0], phy_txc};
    st_next.col_s = {st_reg.col_s[0], phy_col};
    st_next.pause_req = 1'b0;
    st_next.tx_abort = 1'b0;
    // Register writes; status bits of the control word are read only
    if (reg_wr)
    begin
      case (reg_addr)
        `PFC_OFF_CTL: st_next.ctl = {reg_wdata[31:11], 11'h000};
        `PFC_OFF_THR: st_next.thr = reg_wdata;
        `PFC_OFF_MAC_CONFIG_WORD: st_next.mac_config_word = reg_wdata;
        `PFC_OFF_MTIM: st_next.mtim = reg_wdata;
        `PFC_OFF_SAL: st_next.sal = reg_wdata;
        `PFC_OFF_SAH: st_next.sah = {16'h0000, reg_wdata[15:0]};
        default: st_next.ctl = st_reg.ctl;
      endcase
    end
    st_next.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        `PFC_OFF_CTL:
        begin
          st_next.rdata = st_reg.ctl;
          st_next.rdata[`PFC_ST_CONG] = st_reg.congested;
          st_next.rdata[`PFC_ST_BP] = st_reg.bp;
          st_next.rdata[`PFC_ST_JAM] = st_reg.jam;
          st_next.rdata[`PFC_ST_PAUSE] = st_reg.pause_sticky;
          st_next.rdata[`PFC_ST_LATE] = st_reg.late_sticky;
        end
        `PFC_OFF_THR: st_next.rdata = st_reg.thr;
        `PFC_OFF_MAC_CONFIG_WORD: st_next.rdata = st_reg.mac_config_word;
        `PFC_OFF_MTIM: st_next.rdata = st_reg.mtim;
        `PFC_OFF_SAL: st_next.rdata = st_reg.sal;
        `PFC_OFF_SAH: st_next.rdata = st_reg.sah;
        default: st_next.rdata = 32'h0000_0000;
      endcase
      // Reading the control word clears its sticky bits; a new event wins
      if (reg_addr == `PFC_OFF_CTL)
      begin
        st_next.pause_sticky = 1'b0;
        st_next.late_sticky = 1'b0;
      end
    end
    // Hysteresis keeps the port from toggling around a single mark
    cong_next = st_reg.congested;
    if (queue_depth >= high_mark)
      cong_next = 1'b1;
    else if (queue_depth <= low_mark)
      cong_next = 1'b0;
    st_next.congested = cong_next;
    st_next.bp = st_reg.congested & bp_en;
    st_next.jam = 1'b0;
    case (fc_mode)
      `PFC_FC_PORT:
      begin
        if (st_reg.timer != 16'h0000)
        begin
          st_next.jam = bp_en;
          if (txc_edge)
            st_next.timer = st_reg.timer - 16'h0001;
        end
        else if (st_reg.congested && bp_en)
        begin
          st_next.timer = st_reg.thr[`PFC_THR_DUR_HI:0];
          st_next.jam = 1'b1;
        end
      end
      `PFC_FC_PKT:
      begin
        st_next.timer = 16'h0000;
        st_next.jam = st_reg.congested & bp_en;
      end
      `PFC_FC_FULL:
      begin
        st_next.timer = 16'h0000;
        // Pause on entering congestion, zero pause on leaving it
        if (bp_en && st_reg.mac_config_word[`PFC_MAC_CONFIG_WORD_TX_PAUSE]
            && (cong_next != st_reg.congested))
        begin
          st_next.pause_req = 1'b1;
          st_next.pause_time = cong_next
            ? st_reg.thr[`PFC_THR_DUR_HI:0] : 16'h0000;
          st_next.pause_sticky = 1'b1;
        end
      end
      default: st_next.timer = 16'h0000;
    endcase
    // Collision window counted in link clock edges from frame start
    case (st_reg.tx_st)
      pfc_pkg::TX_IDLE:
      begin
        st_next.bit_cnt = 10'h000;
        if (tx_active)
        begin
          st_next.tx_st = pfc_pkg::TX_XMIT;
          st_next.late_col = 1'b0;
        end
      end
      pfc_pkg::TX_XMIT:
      begin
        if (!tx_active)
          st_next.tx_st = pfc_pkg::TX_IDLE;
        else if (late_hit)
        begin
          st_next.tx_st = pfc_pkg::TX_ABORTED;
          st_next.tx_abort = 1'b1;
          st_next.late_col = 1'b1;
          st_next.late_sticky = 1'b1;
        end
        else if (txc_edge && st_reg.bit_cnt != 10'h3ff)
          st_next.bit_cnt = st_reg.bit_cnt + 10'h001;
      end
      pfc_pkg::TX_ABORTED:
      begin
        if (!tx_active)
          st_next.tx_st = pfc_pkg::TX_IDLE;
      end
      default: st_next.tx_st = pfc_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
      st_reg.ctl <= `PFC_CTL_RESET;
      st_reg.tx_st <= pfc_pkg::TX_IDLE;
    end
    else
      st_reg <= st_next;
  end

  assign reg_rdata = st_reg.rdata;
  assign backpressure = st_reg.bp;
  assign bp_mode = st_reg.ctl[`PFC_CTL_BP_MODE];
  assign hd_jam = st_reg.jam;
  assign pause_req = st_reg.pause_req;
  assign pause_time = st_reg.pause_time;
  assign pause_src_addr = {st_reg.sah[15:0], st_reg.sal};
  assign rx_pause_en = st_reg.mac_config_word[`PFC_MAC_CONFIG_WORD_RX_PAUSE];
  assign tx_abort = st_reg.tx_abort;
  assign late_col = st_reg.late_col;

  sequence s_late_seen;
    late_hit && tx_active;
  endsequence
  sequence s_abort_out;
    tx_abort && late_col ##1 !tx_abort;
  endsequence

  chk_bp_when_off: assert property (
    @(posedge clock) disable iff (!rstn)
    !bp_en |=> !backpressure)
    else $error("backpressure while disabled");
  chk_bp_follows_cong: assert property (
    @(posedge clock) disable iff (!rstn)
    st_reg.congested && bp_en |=> backpressure)
    else $error("backpressure missing while congested");
  chk_cong_high_mark: assert property (
    @(posedge clock) disable iff (!rstn)
    queue_depth >= high_mark |=> st_reg.congested)
    else $error("congestion not set at high mark");
  chk_cong_hold_band: assert property (
    @(posedge clock) disable iff (!rstn)
    st_reg.congested && queue_depth > low_mark |=> st_reg.congested)
    else $error("congestion dropped above low mark");
  chk_pkt_jam: assert property (
    @(posedge clock) disable iff (!rstn)
    fc_mode == `PFC_FC_PKT && st_reg.congested && bp_en |=> hd_jam)
    else $error("per-packet jam missing");
  chk_port_timer_load: assert property (
    @(posedge clock) disable iff (!rstn)
    fc_mode == `PFC_FC_PORT && st_reg.timer == 16'h0000 && st_reg.congested
    && bp_en |=> st_reg.timer == $past(st_reg.thr[15:0]))
    else $error("per-port timer not loaded");
  chk_timer_step: assert property (
    @(posedge clock) disable iff (!rstn)
    fc_mode == `PFC_FC_PORT && st_reg.timer != 16'h0000 && txc_edge
    |=> st_reg.timer == $past(st_reg.timer) - 16'h0001)
    else $error("per-port timer did not count down");
  chk_port_jam_hold: assert property (
    @(posedge clock) disable iff (!rstn)
    fc_mode == `PFC_FC_PORT && st_reg.timer != 16'h0000 && bp_en
    |=> hd_jam)
    else $error("per-port jam dropped while timing");
  chk_jam_needs_en: assert property (
    @(posedge clock) disable iff (!rstn)
    !bp_en |=> !hd_jam)
    else $error("jam while backpressure disabled");
  chk_full_no_jam: assert property (
    @(posedge clock) disable iff (!rstn)
    fc_mode == `PFC_FC_FULL |=> !hd_jam)
    else $error("half duplex jam in full duplex mode");
  chk_pause_time_src: assert property (
    @(posedge clock) disable iff (!rstn)
    pause_req |-> (pause_time == $past(st_reg.thr[15:0])
    || pause_time == 16'h0000))
    else $error("pause time not from threshold word");
  chk_pause_gated: assert property (
    @(posedge clock) disable iff (!rstn)
    pause_req |-> $past(fc_mode) == `PFC_FC_FULL && $past(bp_en)
    && $past(st_reg.mac_config_word[`PFC_MAC_CONFIG_WORD_TX_PAUSE]))
    else $error("pause request outside full duplex");
  chk_pause_sticky: assert property (
    @(posedge clock) disable iff (!rstn)
    pause_req |-> st_reg.pause_sticky)
    else $error("pause status bit not set");
  chk_late_abort: assert property (
    @(posedge clock) disable iff (!rstn)
    s_late_seen |=> s_abort_out)
    else $error("late collision did not abort");
  chk_window_hold: assert property (
    @(posedge clock) disable iff (!rstn)
    st_reg.tx_st == pfc_pkg::TX_XMIT && col_now
    && st_reg.bit_cnt <= cw_limit |=> !tx_abort)
    else $error("abort inside collision window");
  chk_abort_holds: assert property (
    @(posedge clock) disable iff (!rstn)
    tx_abort |-> st_reg.tx_st == pfc_pkg::TX_ABORTED)
    else $error("abort without holding the frame aborted");
  chk_late_status: assert property (
    @(posedge clock) disable iff (!rstn)
    $rose(late_col) |-> tx_abort && st_reg.late_sticky)
    else $error("late flag without abort");
  chk_late_clear: assert property (
    @(posedge clock) disable iff (!rstn)
    st_reg.tx_st == pfc_pkg::TX_IDLE && tx_active |=> !late_col)
    else $error("late flag not cleared at frame start");
  chk_status_read: assert property (
    @(posedge clock) disable iff (!rstn)
    reg_rd && reg_addr == `PFC_OFF_CTL |=> reg_rdata[0]
    == $past(st_reg.congested))
    else $error("congestion status misread");
endmodule // pfc_port

// *** tb/pfc_phy_model.sv ***
// Link side model: transmit clock during frames and a collision pin.
// Assumes tx_active marks a frame; col_edge of 0 means no collision.
`timescale 1ns/1ps
module pfc_phy_model (
  input wire logic tx_active,
  input wire logic [7:0] col_edge,
  output logic phy_txc,
  output logic phy_col
);
  int edges = 0;
  initial
  begin
    phy_txc = 1'b0;
    phy_col = 1'b0;
  end
  // Clock stands still between frames, so counts restart per frame
  always
  begin
    wait (tx_active);
    edges = 0;
    while (tx_active)
    begin
      #62.5 phy_txc = 1'b1;
      edges++;
      // A collision lasts one link cycle, so an early one is not seen late
      phy_col = (edges == col_edge);
      #62.5 phy_txc = 1'b0;
    end
    phy_col = 1'b0;
  end
endmodule // pfc_phy_model

// *** tb/port_flow_control_backpressure_tb.sv ***
// Bench for pfc_port: registers, flow control modes, late collision.
// Assumes pfc_phy_model supplies the link clock and collision pin.
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module port_flow_control_backpressure_tb;
  logic clock = 0, rstn = 0, reg_wr = 0, reg_rd = 0, tx_active = 0;
  logic [7:0] reg_addr = 0, col_edge = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, thr;
  logic [6:0] queue_depth = 0, hi, lo;
  logic phy_txc, phy_col, backpressure, bp_mode, hd_jam, pause_req;
  logic rx_pause_en, tx_abort, late_col;
  logic [15:0] pause_time;
  logic [47:0] pause_src_addr, sa;
  int num_errors = 0, checks_done = 0, cyc = 0, aborts = 0;
  always #2.5 clock = ~clock;
  pfc_port pfc_port_inst (.clock(clock), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .queue_depth(queue_depth),
    .tx_active(tx_active), .phy_txc(phy_txc), .phy_col(phy_col),
    .backpressure(backpressure), .bp_mode(bp_mode), .hd_jam(hd_jam),
    .pause_req(pause_req), .pause_time(pause_time),
    .pause_src_addr(pause_src_addr), .rx_pause_en(rx_pause_en),
    .tx_abort(tx_abort), .late_col(late_col));
  pfc_phy_model pfc_phy_model_inst (.tx_active(tx_active),
    .col_edge(col_edge), .phy_txc(phy_txc), .phy_col(phy_col));
  task automatic chk(string n, logic [47:0] e, logic [47:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  // Congestion reaches backpressure two edges after the depth changes
  task automatic depth(logic [6:0] d);
    @(posedge clock);
    queue_depth <= d;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic frame(logic [7:0] c);
    aborts = 0;
    col_edge <= c;
    tx_active <= 1'b1;
    repeat (2500) @(posedge clock);
    tx_active <= 1'b0;
    repeat (100) @(posedge clock);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (tx_abort)
      aborts++;
    if (cyc == 20000)
    begin
      num_errors++;
      summarize();
    end
  end
  initial
  begin
    void'($urandom(32'h3b1a9864));
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    // Reset marks are zero, so even an empty queue reads as congested
    rd(`PFC_OFF_CTL, `PFC_CTL_RESET | 32'h0000_0001);
    rd(8'h18, 32'h0);
    hi = 7'd20 + 7'($urandom_range(100));
    lo = hi - 7'd2 - 7'($urandom_range(5));
    thr = {1'b0, hi, 1'b0, lo, 16'($urandom)};
    wr(`PFC_OFF_THR, thr);
    rd(`PFC_OFF_THR, thr);
    sa = 48'({$urandom, $urandom});
    wr(`PFC_OFF_SAL, sa[31:0]);
    wr(`PFC_OFF_SAH, {16'hffff, sa[47:32]});
    rd(`PFC_OFF_SAH, {16'h0, sa[47:32]});
    chk("pause_src_addr", sa, pause_src_addr);
    wr(`PFC_OFF_CTL, 32'h0160_07ff);
    rd(`PFC_OFF_CTL, 32'h0160_0000);
    chk("bp_mode", 1'b1, bp_mode);
    depth(hi - 7'd1);
    chk("backpressure", 1'b0, backpressure);
    depth(hi);
    chk("backpressure", 1'b1, backpressure);
    chk("hd_jam", 1'b1, hd_jam);
    chk("pause_req", 1'b0, pause_req);
    rd(`PFC_OFF_CTL, 32'h0160_0007);
    depth(lo + 7'd1);
    chk("backpressure", 1'b1, backpressure);
    depth(lo);
    chk("backpressure", 1'b0, backpressure);
    wr(`PFC_OFF_CTL, 32'h0100_0000);
    depth(hi);
    chk("backpressure", 1'b0, backpressure);
    chk("hd_jam", 1'b0, hd_jam);
    depth(7'd0);
    wr(`PFC_OFF_MAC_CONFIG_WORD, 32'h0007_0000);
    wr(`PFC_OFF_CTL, 32'h01a0_0000);
    chk("rx_pause_en", 1'b1, rx_pause_en);
    @(posedge clock);
    queue_depth <= hi;
    @(posedge clock);
    #1 chk("pause_req", 1'b1, pause_req);
    chk("pause_time", thr[15:0], pause_time);
    @(posedge clock);
    #1 chk("pause_req", 1'b0, pause_req);
    chk("hd_jam", 1'b0, hd_jam);
    depth(7'd0);
    chk("pause_time", 16'h0000, pause_time);
    wr(`PFC_OFF_CTL, 32'h00a0_0000);
    thr[15:0] = 16'd4;
    wr(`PFC_OFF_THR, thr);
    tx_active <= 1'b1;
    depth(hi);
    depth(lo);
    chk("hd_jam", 1'b1, hd_jam);
    repeat (300) @(posedge clock);
    #1 chk("hd_jam", 1'b0, hd_jam);
    @(posedge clock);
    tx_active <= 1'b0;
    // Let the link clock finish its cycle so the next frame counts from one
    repeat (50) @(posedge clock);
    wr(`PFC_OFF_MTIM, 32'h0000_0010);
    frame(8'd74);
    chk("aborts", 0, aborts);
    chk("late_col", 1'b0, late_col);
    frame(8'd86);
    chk("aborts", 1, aborts);
    chk("late_col", 1'b1, late_col);
    rd(`PFC_OFF_CTL, 32'h00a0_0018);
    rd(`PFC_OFF_CTL, 32'h00a0_0000);
    frame(8'd0);
    chk("late_col", 1'b0, late_col);
    summarize();
  end
endmodule // port_flow_control_backpressure_tb
